// ### hdl/mic_regs.svh
// Register map, field positions and timing constants
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

`define MIC_IDX_CTRL   10'h00b
`define MIC_IDX_PFLAG  10'h00c
`define MIC_IDX_PENAB  10'h08c
`define MIC_IDX_OPT    10'h081
`define MIC_IDX_STS    10'h0f0
`define MIC_IDX_MSK    10'h0f1

`define MIC_RST_BYTE   8'h00
`define MIC_RST_OPT    8'h00
`define MIC_RST_EVT    2'h0

`define MIC_B_GLOBAL_EN 7
`define MIC_B_GROUP_EN  6
`define MIC_B_OVF0_EN   5
`define MIC_B_PIN_EN    4
`define MIC_B_PORT_EN   3
`define MIC_B_OVF0_FL   2
`define MIC_B_PIN_FL    1
`define MIC_B_PORT_FL   0

`define MIC_B_NVM_FL    7
`define MIC_B_ADC_FL    6
`define MIC_B_CMP_FL    3
`define MIC_B_OVF1_FL   0
`define MIC_PFLAG_IMPL  8'hc9

`define MIC_B_EDGE     6

`define MIC_EV_TAKE    0
`define MIC_EV_WAKE    1

`define MIC_VECTOR     13'h0004
`define MIC_Q_LAST     2'h3

`define MIC_RESP_OK    2'h0
`define MIC_RESP_DEC   2'h3
`endif

// ### hdl/mic_pkg.sv
// Types shared by the interrupt controller modules
package mic_pkg;
  typedef logic [7:0] mic_byte_t;
  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_DUMMY1,
    MIC_DUMMY2
  } mic_seq_e;
endpackage

// ### hdl/mic_gate_if.sv
// Flags and enables carried to the request gate
interface mic_gate_if;
  mic_pkg::mic_byte_t ctrl;
  mic_pkg::mic_byte_t pflags;
  mic_pkg::mic_byte_t penab;
  logic               glb_en;
  logic               wake_req;
  logic               pending;
  modport ctl  (output ctrl, pflags, penab, glb_en, input wake_req, pending);
  modport gate (input ctrl, pflags, penab, glb_en, output wake_req, pending);
endinterface

// ### hdl/mic_gate.sv
// Request gate: per-source enables, group enable, global enable
`include "mic_regs.svh"
module mic_gate (
  mic_gate_if.gate g  // Flags and enables in, requests out
);
  wire [2:0] core_en;
  wire [2:0] core_fl;
  wire       core_hit;
  wire       periph_hit;
  wire       group_hit;

  assign core_en = {g.ctrl[`MIC_B_OVF0_EN], g.ctrl[`MIC_B_PIN_EN],
                    g.ctrl[`MIC_B_PORT_EN]};
  assign core_fl = {g.ctrl[`MIC_B_OVF0_FL], g.ctrl[`MIC_B_PIN_FL],
                    g.ctrl[`MIC_B_PORT_FL]};
  assign core_hit   = |(core_en & core_fl);
  assign periph_hit = |(g.pflags & g.penab & `MIC_PFLAG_IMPL);
  assign group_hit  = periph_hit & g.ctrl[`MIC_B_GROUP_EN];
  assign g.wake_req = core_hit | group_hit;
  assign g.pending  = g.glb_en & g.wake_req;
endmodule

// ### hdl/mic_top.sv
// Interrupt controller with AXI4-Lite register access
// Contract
// - Seven sources: pin edge, timer0, port change, comparator, A/D, timer1, EEPROM.
// - Global enable bit 7 passes unmasked requests, blocks all when clear.
// - Every reset clears the global enable.
// - Return-from-interrupt sets the global enable again.
// - Each source has its own enable bit masking it.
// - Pin, port change and timer0 flags live in core control register.
// - EEPROM, A/D, comparator, timer1 flags and enables in peripheral registers.
// - Service clears global enable, pushes return address, vectors to 0004h.
// - External events reach the vector in three or four instruction cycles.
// - Flags set by events regardless of any enable bit.
// - Clearing global enable ignores next-cycle requests, which stay pending.
// - Wake with global enable set vectors to 0004h, else continues.
// - Wake sets the causing peripheral flag: bits 7, 6, 3, 0.
// - Pin edge select: set rising, clear falling; valid edge sets flag.
// - Timer0 wrap to zero sets flag bit 2 of core control.
// - Pin interrupt wakes from sleep when its enable was set.
// - A/D completion sets flag bit 6 of peripheral flags.
`include "mic_regs.svh"
module mic_top (
  input  wire logic        aclk,            // Clock, 20 MHz
  input  wire logic        aresetn,         // Sync reset, active low
  input  wire logic [11:0] s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [11:0] s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  output logic             irq,             // Level interrupt out
  input  wire logic        ext_irq_pin,     // External pin, async
  input  wire logic        timer0_ovf,      // Timer0 wrap pulse
  input  wire logic        port_change,     // Port change pulse
  input  wire logic        cmp_change,      // Comparator pulse
  input  wire logic        adc_done,        // A/D done pulse
  input  wire logic        timer1_ovf,      // Timer1 wrap pulse
  input  wire logic        eeprom_done,     // EEPROM write pulse
  input  wire logic        core_sleep,      // Core is asleep
  input  wire logic        return_from_irq, // Return instruction
  output logic             irq_take,        // Push return address
  output logic             irq_vector,      // Load vector_pc
  output logic [12:0]      vector_pc,       // Vector address
  output logic             wake             // Wake-up pulse
);
  mic_gate_if gi ();

  mic_pkg::mic_byte_t ctrl_r;
  mic_pkg::mic_byte_t ctrl_nxt;
  mic_pkg::mic_byte_t pflag_r;
  mic_pkg::mic_byte_t pflag_nxt;
  mic_pkg::mic_byte_t penab_r;
  mic_pkg::mic_byte_t opt_r;
  logic [1:0]         sts_r;
  logic [1:0]         msk_r;
  mic_pkg::mic_seq_e  seq_r;
  mic_pkg::mic_seq_e  seq_nxt;
  logic [1:0]         qcnt_r;
  logic               sync1_r;
  logic               sync2_r;
  logic               sync3_r;
  logic               pin_lvl_r;
  logic               aw_held_r;
  logic               w_held_r;
  logic [9:0]         aw_idx_r;
  logic [7:0]         w_data_r;
  logic               w_lane_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic               take_r;
  logic               vec_r;
  logic               wake_r;
  logic               woke_r;

  // Instruction cycle tick every four clocks
  wire tick = (qcnt_r == `MIC_Q_LAST);

  // Pin edge once second and third stage agree
  wire pin_stable = (sync2_r == sync3_r);
  wire pin_rise   = pin_stable & sync2_r & ~pin_lvl_r;
  wire pin_fall   = pin_stable & ~sync2_r & pin_lvl_r;
  wire edge_rise  = opt_r[`MIC_B_EDGE];
  wire pin_event  = edge_rise ? pin_rise : pin_fall;

  // Bus write decode
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_r | aw_hs;
  wire w_have  = w_held_r | w_hs;
  wire [9:0] aw_idx  = aw_held_r ? aw_idx_r : s_axi_awaddr[11:2];
  wire [7:0] w_byte  = w_held_r ? w_data_r : s_axi_wdata[7:0];
  wire       w_lane  = w_held_r ? w_lane_r : s_axi_wstrb[0];
  wire wr_go   = aw_have & w_have & ~bvalid_r;
  wire wr_en   = wr_go & w_lane;
  wire wr_ctrl  = wr_en & (aw_idx == `MIC_IDX_CTRL);
  wire wr_pflag = wr_en & (aw_idx == `MIC_IDX_PFLAG);
  wire wr_penab = wr_en & (aw_idx == `MIC_IDX_PENAB);
  wire wr_opt   = wr_en & (aw_idx == `MIC_IDX_OPT);
  wire wr_sts   = wr_en & (aw_idx == `MIC_IDX_STS);
  wire wr_msk   = wr_en & (aw_idx == `MIC_IDX_MSK);
  wire wr_hit   = (aw_idx == `MIC_IDX_CTRL) | (aw_idx == `MIC_IDX_PFLAG) |
                  (aw_idx == `MIC_IDX_PENAB) | (aw_idx == `MIC_IDX_OPT) |
                  (aw_idx == `MIC_IDX_STS) | (aw_idx == `MIC_IDX_MSK);
  wire [1:0] wr_resp = wr_hit ? `MIC_RESP_OK : `MIC_RESP_DEC;

  // Bus read decode
  wire [9:0] ar_idx = s_axi_araddr[11:2];
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire rd_ctrl  = (ar_idx == `MIC_IDX_CTRL);
  wire rd_pflag = (ar_idx == `MIC_IDX_PFLAG);
  wire rd_penab = (ar_idx == `MIC_IDX_PENAB);
  wire rd_opt   = (ar_idx == `MIC_IDX_OPT);
  wire rd_sts   = (ar_idx == `MIC_IDX_STS);
  wire rd_msk   = (ar_idx == `MIC_IDX_MSK);
  wire rd_hit   = rd_ctrl | rd_pflag | rd_penab | rd_opt | rd_sts | rd_msk;
  wire [1:0] rd_resp = rd_hit ? `MIC_RESP_OK : `MIC_RESP_DEC;
  wire [7:0] rd_byte = ({8{rd_ctrl}} & ctrl_r) |
                       ({8{rd_pflag}} & pflag_r) |
                       ({8{rd_penab}} & penab_r) |
                       ({8{rd_opt}} & opt_r) |
                       ({8{rd_sts}} & {6'h00, sts_r}) |
                       ({8{rd_msk}} & {6'h00, msk_r});

  // Software clearing the global enable blocks this cycle's sampling
  wire glb_sw_clr = wr_ctrl & ~w_byte[`MIC_B_GLOBAL_EN];
  wire glb_eff    = ctrl_r[`MIC_B_GLOBAL_EN] & ~glb_sw_clr;

  // Service starts only on an instruction tick while running
  wire start_take = tick & (seq_r == mic_pkg::MIC_RUN) & gi.pending;
  wire vec_fire   = tick & (seq_r == mic_pkg::MIC_DUMMY2);
  wire wake_fire  = core_sleep & gi.wake_req & ~woke_r;
  wire woke_nxt   = core_sleep & (woke_r | wake_fire);

  // Status bits: hardware sets, a written one clears
  wire [1:0] sts_set = {wake_fire, start_take};
  wire [1:0] sts_clr = {2{wr_sts}} & w_byte[1:0];

  assign gi.ctrl   = ctrl_r;
  assign gi.pflags = pflag_r;
  assign gi.penab  = penab_r;
  assign gi.glb_en = glb_eff;

  mic_gate mic_gate_i (
    .g (gi.gate)
  );

  // Core control: software value, then hardware sets and enable control
  always_comb
  begin
    ctrl_nxt = wr_ctrl ? w_byte : ctrl_r;
    ctrl_nxt[`MIC_B_OVF0_FL] = ctrl_nxt[`MIC_B_OVF0_FL] | timer0_ovf;
    ctrl_nxt[`MIC_B_PIN_FL] = ctrl_nxt[`MIC_B_PIN_FL] | pin_event;
    ctrl_nxt[`MIC_B_PORT_FL] = ctrl_nxt[`MIC_B_PORT_FL] | port_change;
    if (start_take)
      ctrl_nxt[`MIC_B_GLOBAL_EN] = 1'b0;
    else if (return_from_irq)
      ctrl_nxt[`MIC_B_GLOBAL_EN] = 1'b1;
  end

  // Peripheral flags: set wins over a clearing write
  always_comb
  begin
    pflag_nxt = (wr_pflag ? w_byte : pflag_r) & `MIC_PFLAG_IMPL;
    pflag_nxt[`MIC_B_NVM_FL] = pflag_nxt[`MIC_B_NVM_FL] | eeprom_done;
    pflag_nxt[`MIC_B_ADC_FL] = pflag_nxt[`MIC_B_ADC_FL] | adc_done;
    pflag_nxt[`MIC_B_CMP_FL] = pflag_nxt[`MIC_B_CMP_FL] | cmp_change;
    pflag_nxt[`MIC_B_OVF1_FL] = pflag_nxt[`MIC_B_OVF1_FL] | timer1_ovf;
  end

  // Vector sequence: two dummy cycles, then the vector
  always_comb
  begin
    seq_nxt = seq_r;
    if (tick)
    begin
      unique case (seq_r)
        mic_pkg::MIC_RUN:    if (gi.pending) seq_nxt = mic_pkg::MIC_DUMMY1;
        mic_pkg::MIC_DUMMY1: seq_nxt = mic_pkg::MIC_DUMMY2;
        mic_pkg::MIC_DUMMY2: seq_nxt = mic_pkg::MIC_RUN;
        default:             seq_nxt = mic_pkg::MIC_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r  <= `MIC_RST_BYTE;
      pflag_r <= `MIC_RST_BYTE;
      penab_r <= `MIC_RST_BYTE;
      opt_r   <= `MIC_RST_OPT;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      pflag_r <= pflag_nxt;
      if (wr_penab)
        penab_r <= w_byte & `MIC_PFLAG_IMPL;
      if (wr_opt)
        opt_r <= w_byte;
    end
  end

  // Event status and mask; a new event beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sts_r <= `MIC_RST_EVT;
      msk_r <= `MIC_RST_EVT;
    end
    else
    begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
      if (wr_msk)
        msk_r <= w_byte[1:0];
    end
  end

  // Divider and pin synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      qcnt_r    <= 2'h0;
      sync1_r   <= 1'b0;
      sync2_r   <= 1'b0;
      sync3_r   <= 1'b0;
      pin_lvl_r <= 1'b0;
    end
    else
    begin
      qcnt_r  <= qcnt_r + 2'h1;
      sync1_r <= ext_irq_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (pin_stable)
        pin_lvl_r <= sync2_r;
    end
  end

  // Core handshake and wake-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_r  <= mic_pkg::MIC_RUN;
      take_r <= 1'b0;
      vec_r  <= 1'b0;
      wake_r <= 1'b0;
      woke_r <= 1'b0;
    end
    else
    begin
      seq_r  <= seq_nxt;
      take_r <= start_take;
      vec_r  <= vec_fire;
      wake_r <= wake_fire;
      woke_r <= woke_nxt;
    end
  end

  // Write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_idx_r  <= 10'h000;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MIC_RESP_OK;
    end
    else
    begin
      if (aw_hs)
        aw_idx_r <= s_axi_awaddr[11:2];
      if (w_hs)
      begin
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      aw_held_r <= aw_have & ~wr_go;
      w_held_r  <= w_have & ~wr_go;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_resp;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `MIC_RESP_OK;
    end
    else if (ar_hs)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= rd_resp;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = |(sts_r & msk_r);
  assign irq_take      = take_r;
  assign irq_vector    = vec_r;
  assign vector_pc     = `MIC_VECTOR;
  assign wake          = wake_r;
endmodule

// ### dv/mic_core_model.sv
// Core sequencer model: leaves the service routine on request
module mic_core_model (
  input  wire logic aclk,            // Clock
  input  wire logic aresetn,         // Sync reset, active low
  input  wire logic irq_vector,      // Vector load from controller
  input  wire logic isr_done,        // Handler has cleared its flags
  output logic      return_from_irq  // Return instruction pulse
);
  logic in_isr_r;

  // Return only once the handler reports its flags cleared
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_isr_r        <= 1'b0;
      return_from_irq <= 1'b0;
    end
    else
    begin
      return_from_irq <= in_isr_r & isr_done;
      if (irq_vector)
        in_isr_r <= 1'b1;
      else if (isr_done)
        in_isr_r <= 1'b0;
    end
  end
endmodule

// ### dv/mic_top_assertions.sv
// Port checker of the interrupt controller
`include "mic_regs.svh"
module mic_top_assertions (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Sync reset, active low
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_bready,  // Write response ready
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        s_axi_rready,  // Read data ready
  input wire logic        s_axi_arready, // Read address ready
  input wire logic        irq_take,      // Service start
  input wire logic        irq_vector,    // Vector load
  input wire logic [12:0] vector_pc,     // Vector address
  input wire logic        wake           // Wake pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_take;
    irq_take ##1 !irq_take;
  endsequence
  sequence s_dummy;
    !irq_vector [*7] ##1 irq_vector;
  endsequence

  chk_take_then_vector: assert property (s_take |-> s_dummy)
    else $error("vector load did not follow service start");
  chk_vector_cause: assert property (
    irq_vector |-> $past(irq_take, 8))
    else $error("vector load without service start");
  chk_vector_addr: assert property (
    irq_vector |-> vector_pc == `MIC_VECTOR)
    else $error("wrong vector address");
  chk_take_spacing: assert property (
    irq_take |=> !irq_take [*8])
    else $error("second service start too soon");
  chk_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
endmodule

bind mic_top mic_top_assertions mic_top_assertions_i (.*);

// ### dv/mic_top_tb.sv
// Self-checking bench for the interrupt controller
`include "mic_regs.svh"
module mic_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] a_ctrl = {`MIC_IDX_CTRL, 2'h0};
  localparam logic [11:0] a_pf   = {`MIC_IDX_PFLAG, 2'h0};
  localparam logic [11:0] a_pe   = {`MIC_IDX_PENAB, 2'h0};
  localparam logic [11:0] a_opt  = {`MIC_IDX_OPT, 2'h0};
  localparam logic [11:0] a_sts  = {`MIC_IDX_STS, 2'h0};
  localparam logic [11:0] a_msk  = {`MIC_IDX_MSK, 2'h0};
  logic aclk = 0, aresetn = 0, ext_irq_pin = 0, core_sleep = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, isr_done = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [12:0] vector_pc;
  logic [5:0]  src = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, irq_take, irq_vector, wake, return_from_irq;
  wire timer0_ovf = src[0], port_change = src[1], cmp_change = src[2];
  wire adc_done = src[3], timer1_ovf = src[4], eeprom_done = src[5];
  int miscompares = 0, n_tests = 0, n_take = 0, n_wake = 0;
  logic [11:0] ra [6] = '{a_ctrl, a_pf, a_pe, a_opt, a_msk, 12'h100};
  logic [7:0]  rw [6] = '{8'h07, 8'hff, 8'hff, 8'h40, 8'h03, 8'hff};
  logic [7:0]  rr [6] = '{8'h07, 8'hc9, 8'hc9, 8'h40, 8'h03, 8'h00};

  always #25 aclk = ~aclk;
  mic_top mic_top_i (.*);
  mic_core_model mic_core_model_i (.*);

  always @(posedge aclk)
  begin
    n_take <= n_take + (irq_take === 1'b1);
    n_wake <= n_wake + (wake === 1'b1);
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(logic [11:0] a, logic [7:0] d);
    logic aw, w, b;
    aw = 1;
    w = 1;
    b = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw | w | b)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 0;
      if (s_axi_wready === 1'b1) w = 0;
      if (s_axi_bvalid === 1'b1) b = 0;
      if (s_axi_bvalid === 1'b1) resp = s_axi_bresp;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= b;
    end
  endtask

  task automatic rd(logic [11:0] a, logic [7:0] e);
    logic ar, r;
    ar = 1;
    r = 1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (ar | r)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) ar = 0;
      if (s_axi_rvalid === 1'b1) r = 0;
      if (s_axi_rvalid === 1'b1) rdat = s_axi_rdata;
      if (s_axi_rvalid === 1'b1) resp = s_axi_rresp;
      s_axi_arvalid <= ar;
      s_axi_rready <= r;
    end
    chk("rdata", rdat, {24'h0, e});
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
  endtask

  initial
  begin
    cyc(20000);
    miscompares++;
    end_sim;
  end

  initial
  begin
    cyc(4);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(a_ctrl, 8'h00);
    chk("irq", irq, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      wr(ra[i], rw[i]);
      chk("bresp", resp, i == 5 ? `MIC_RESP_DEC : `MIC_RESP_OK);
      rd(ra[i], rr[i]);
      chk("rresp", resp, i == 5 ? `MIC_RESP_DEC : `MIC_RESP_OK);
      wr(ra[i], 8'h00);
    end
    $display("test register map done");
    ext_irq_pin <= 1'b1;
    cyc(12);
    rd(a_ctrl, 8'h00);
    ext_irq_pin <= 1'b0;
    src <= 6'h3f;
    @(posedge aclk);
    src <= 6'h00;
    cyc(12);
    rd(a_ctrl, 8'h07);
    rd(a_pf, 8'hc9);
    wr(a_ctrl, 8'h87);
    cyc(20);
    chk("take", n_take, 0);
    wr(a_ctrl, 8'h00);
    wr(a_pf, 8'h00);
    wr(a_opt, 8'h40);
    ext_irq_pin <= 1'b1;
    cyc(12);
    rd(a_ctrl, 8'h02);
    wr(a_ctrl, 8'h00);
    ext_irq_pin <= 1'b0;
    $display("test flags done");
    wr(a_msk, 8'h01);
    wr(a_pe, 8'h40);
    wr(a_ctrl, 8'h80);
    src <= 6'h08;
    @(posedge aclk);
    src <= 6'h00;
    cyc(20);
    chk("take", n_take, 0);
    wr(a_ctrl, 8'hc0);
    cyc(20);
    chk("take", n_take, 1);
    rd(a_ctrl, 8'h40);
    chk("irq", irq, 1'b1);
    wr(a_sts, 8'h01);
    chk("irq", irq, 1'b0);
    wr(a_pf, 8'h00);
    isr_done <= 1'b1;
    cyc(3);
    isr_done <= 1'b0;
    rd(a_ctrl, 8'hc0);
    cyc(20);
    chk("take", n_take, 1);
    $display("test service done");
    wr(a_ctrl, 8'h10);
    core_sleep <= 1'b1;
    ext_irq_pin <= 1'b1;
    cyc(20);
    chk("wake", n_wake, 1);
    chk("take", n_take, 1);
    rd(a_ctrl, 8'h12);
    core_sleep <= 1'b0;
    $display("test wake done");
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(a_ctrl, 8'h80);
    s_axi_wstrb <= 4'hf;
    rd(a_ctrl, 8'h00);
    $display("test reset done");
    end_sim;
  end
endmodule
